// ### auto_reload_timers.sv
// Timer 0 (16-bit) and timers 1 and 2 (8-bit) with register port and overflow requests.
//
// Summary of operation
// - Wide timer counts selected clock pulses while its run bit is one; else holds.
// - Wide overflow raises request, reloads counter, inverts wide output.
// - Wide output level is control bit 7.
// - Count, overflow, reload, toggle repeats until run bit is cleared.
// - Writing wide counter also writes wide reload register.
// - Event pin selection turns the timer into an event counter.
// - Event pins are sampled and count pulses derived from the samples.
// - Wide overflow sets its request flag in interrupt request register one.
// - Wide interrupt is forwarded only while its enable flag is set.
// - Two priority flags select one of four levels for wide interrupt.
// - Wide overflow interrupt uses vector 001A hex.
// - Timers 1 and 2 are 8-bit up-counters raising requests and reloading.
// - Writing an 8-bit counter also writes its reload register.
// - Counters and reload registers have no defined reset value to rely on.
// - Timer 1 bits 2..0 select base clock dividers or event edges.
// - Timer 1 bit 3 starts or halts counting.
// - Timer 1 bit 7 is output level, inverted on every timer 1 overflow unless timers are joined.
// - Timer 1 control bits 4 to 6 ignore writes and read one.
// - Timer 1 control resets to 70 hex.
// - Timers 1 and 2 work alone or combined as one 16-bit timer.
// - Timer 2 bit 4 joins timers; timer 2 select and run are then ignored.
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module auto_reload_timers
   import timers_pkg::*;
(
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic nrst_in,
   // Register port
   input wire logic [7:0] addr_in,
   input wire logic [15:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [15:0] rdata_out,
   // Event pins
   input wire logic wide_timer_event_in,
   input wire logic timer1_event_in,
   input wire logic timer2_event_in,
   // Timer output pins
   output logic wide_timer_output_out,
   output logic timer1_output_out,
   output logic timer2_output_out,
   // Interrupt requests towards the interrupt controller
   output logic wide_irq_out,
   output logic [1:0] wide_irq_priority_out,
   output logic [15:0] wide_irq_vector_out,
   output logic timer1_irq_out,
   output logic timer2_irq_out
);

   ////////////////////////////////////////////////////////////////////////////////
   // State.

   typedef struct packed {
      logic [15:0] wide_count;
      logic [15:0] wide_reload;
      logic [7:0] wide_control;
      logic [7:0] timer1_count;
      logic [7:0] timer2_count;
      logic [7:0] timer1_reload;
      logic [7:0] timer2_reload;
      logic [7:0] timer1_control;
      logic [7:0] timer2_control;
      logic [2:0] int_request;
      logic [2:0] int_enable;
      logic [1:0] int_priority;
      logic [7:0] prescale;
      logic [2:0] sync1;
      logic [2:0] sync2;
      logic [2:0] sync3;
      logic [2:0] evt_level;
      logic [15:0] rdata;
      logic wide_irq;
      logic timer1_irq;
      logic timer2_irq;
      logic [1:0] priority_out;
      logic [15:0] vector_out;
   } state_t;

   state_t s_q;
   state_t s_d;

   ////////////////////////////////////////////////////////////////////////////////
   // Helpers.

   // Count pulse for one timer from its clock select, the shared prescaler and its event edges.
   function automatic logic count_pulse(input logic [2:0] sel, input logic [7:0] pre,
                                        input logic rise, input logic fall);
      logic p;
      p = 1'b0;
      case (sel)
         SEL_DIV1: p = 1'b1;
         SEL_DIV2: p = pre[0];
         SEL_DIV4: p = &pre[1:0];
         SEL_DIV8: p = &pre[2:0];
         SEL_DIV32: p = &pre[4:0];
         SEL_DIV256: p = &pre[7:0];
         SEL_EVT_RISE: p = rise;
         SEL_EVT_FALL: p = fall;
         default: p = 1'b0;
      endcase
      return p;
   endfunction

   // Write to a control register: fixed bits stay one whatever is written.
   function automatic logic [7:0] ctrl_write(input logic [7:0] data, input logic [7:0] ones);
      return data | ones;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Next state.

   logic [2:0] stable;
   logic [2:0] evt_rise;
   logic [2:0] evt_fall;
   logic wide_tick;
   logic t1_tick;
   logic t2_tick;
   logic paired;
   logic wide_ovf;
   logic t1_ovf;
   logic t2_ovf;
   logic pair_ovf;

   always_comb begin
      s_d = s_q;

      // Base clock divider runs free so every divided select shares one phase.
      s_d.prescale = s_q.prescale + 8'h01;

      // Three-stage event samplers; a new level is accepted once stages two and three agree.
      s_d.sync1 = {timer2_event_in, timer1_event_in, wide_timer_event_in};
      s_d.sync2 = s_q.sync1;
      s_d.sync3 = s_q.sync2;
      stable = ~(s_q.sync2 ^ s_q.sync3);
      evt_rise = stable & s_q.sync3 & ~s_q.evt_level;
      evt_fall = stable & ~s_q.sync3 & s_q.evt_level;
      s_d.evt_level = (stable & s_q.sync3) | (~stable & s_q.evt_level);

      paired = s_q.timer2_control[PAIR_WIDE_BIT];
      wide_tick = s_q.wide_control[RUN_BIT] &
                  count_pulse(s_q.wide_control[2:0], s_q.prescale, evt_rise[0], evt_fall[0]);
      t1_tick = s_q.timer1_control[RUN_BIT] &
                count_pulse(s_q.timer1_control[2:0], s_q.prescale, evt_rise[1], evt_fall[1]);
      // While joined, timer 2's own select and run are ignored.
      t2_tick = ~paired & s_q.timer2_control[RUN_BIT] &
                count_pulse(s_q.timer2_control[2:0], s_q.prescale, evt_rise[2], evt_fall[2]);

      wide_ovf = wide_tick & (&s_q.wide_count);
      t1_ovf = ~paired & t1_tick & (&s_q.timer1_count);
      t2_ovf = t2_tick & (&s_q.timer2_count);
      pair_ovf = paired & t1_tick & (&s_q.timer1_count) & (&s_q.timer2_count);

      // Wide timer: count, or on overflow reload, toggle and request.
      if (wide_ovf) begin
         s_d.wide_count = s_q.wide_reload;
         s_d.wide_control[OUTPUT_BIT] = ~s_q.wide_control[OUTPUT_BIT];
      end else if (wide_tick) begin
         s_d.wide_count = s_q.wide_count + 16'h0001;
      end

      // Timers 1 and 2, alone or joined with timer 1 as the low byte.
      if (paired) begin
         if (pair_ovf) begin
            s_d.timer1_count = s_q.timer1_reload;
            s_d.timer2_count = s_q.timer2_reload;
            s_d.timer2_control[OUTPUT_BIT] = ~s_q.timer2_control[OUTPUT_BIT];
         end else if (t1_tick) begin
            s_d.timer1_count = s_q.timer1_count + 8'h01;
            if (&s_q.timer1_count) begin
               s_d.timer2_count = s_q.timer2_count + 8'h01;
            end
         end
      end else begin
         if (t1_ovf) begin
            s_d.timer1_count = s_q.timer1_reload;
            s_d.timer1_control[OUTPUT_BIT] = ~s_q.timer1_control[OUTPUT_BIT];
         end else if (t1_tick) begin
            s_d.timer1_count = s_q.timer1_count + 8'h01;
         end
         if (t2_ovf) begin
            s_d.timer2_count = s_q.timer2_reload;
            s_d.timer2_control[OUTPUT_BIT] = ~s_q.timer2_control[OUTPUT_BIT];
         end else if (t2_tick) begin
            s_d.timer2_count = s_q.timer2_count + 8'h01;
         end
      end

      // Register writes. A counter write overrides a same-cycle count or reload.
      if (wr_in) begin
         if (addr_in == WIDE_COUNT_OFS) begin
            s_d.wide_count = wdata_in;
            s_d.wide_reload = wdata_in;
         end else if (addr_in == WIDE_RELOAD_OFS) begin
            s_d.wide_reload = wdata_in;
         end else if (addr_in == WIDE_CONTROL_OFS) begin
            s_d.wide_control = ctrl_write(wdata_in[7:0], WIDE_FIXED_ONES);
         end else if (addr_in == T1_COUNT_OFS) begin
            s_d.timer1_count = wdata_in[7:0];
            s_d.timer1_reload = wdata_in[7:0];
         end else if (addr_in == T2_COUNT_OFS) begin
            s_d.timer2_count = wdata_in[7:0];
            s_d.timer2_reload = wdata_in[7:0];
         end else if (addr_in == T1_RELOAD_OFS) begin
            s_d.timer1_reload = wdata_in[7:0];
         end else if (addr_in == T2_RELOAD_OFS) begin
            s_d.timer2_reload = wdata_in[7:0];
         end else if (addr_in == T1_CONTROL_OFS) begin
            s_d.timer1_control = ctrl_write(wdata_in[7:0], T1_FIXED_ONES);
         end else if (addr_in == T2_CONTROL_OFS) begin
            s_d.timer2_control = ctrl_write(wdata_in[7:0], T2_FIXED_ONES);
         end else if (addr_in == INT_REQUEST_OFS) begin
            s_d.int_request = wdata_in[2:0];
         end else if (addr_in == INT_ENABLE_OFS) begin
            s_d.int_enable = wdata_in[2:0];
         end else if (addr_in == INT_PRIORITY_OFS) begin
            s_d.int_priority = wdata_in[1:0];
         end
      end

      // Overflow sets a request flag after the write, so a set beats a clear in the same cycle.
      if (wide_ovf) begin
         s_d.int_request[WIDE_IRQ_BIT] = 1'b1;
      end
      if (t1_ovf) begin
         s_d.int_request[T1_IRQ_BIT] = 1'b1;
      end
      if (t2_ovf | pair_ovf) begin
         s_d.int_request[T2_IRQ_BIT] = 1'b1;
      end

      // Request lines follow flag and enable; the controller sees them one cycle later.
      s_d.wide_irq = s_q.int_request[WIDE_IRQ_BIT] & s_q.int_enable[WIDE_IRQ_BIT];
      s_d.timer1_irq = s_q.int_request[T1_IRQ_BIT] & s_q.int_enable[T1_IRQ_BIT];
      s_d.timer2_irq = s_q.int_request[T2_IRQ_BIT] & s_q.int_enable[T2_IRQ_BIT];
      s_d.priority_out = s_q.int_priority;
      s_d.vector_out = WIDE_OVF_VECTOR;

      // Read data stands only in the cycle after the read strobe.
      s_d.rdata = 16'h0000;
      if (rd_in) begin
         if (addr_in == WIDE_COUNT_OFS) begin
            s_d.rdata = s_q.wide_count;
         end else if (addr_in == WIDE_RELOAD_OFS) begin
            s_d.rdata = s_q.wide_reload;
         end else if (addr_in == WIDE_CONTROL_OFS) begin
            s_d.rdata = {8'h00, s_q.wide_control | WIDE_FIXED_ONES};
         end else if (addr_in == T1_COUNT_OFS) begin
            s_d.rdata = {8'h00, s_q.timer1_count};
         end else if (addr_in == T2_COUNT_OFS) begin
            s_d.rdata = {8'h00, s_q.timer2_count};
         end else if (addr_in == T1_RELOAD_OFS) begin
            s_d.rdata = {8'h00, s_q.timer1_reload};
         end else if (addr_in == T2_RELOAD_OFS) begin
            s_d.rdata = {8'h00, s_q.timer2_reload};
         end else if (addr_in == T1_CONTROL_OFS) begin
            s_d.rdata = {8'h00, s_q.timer1_control | T1_FIXED_ONES};
         end else if (addr_in == T2_CONTROL_OFS) begin
            s_d.rdata = {8'h00, s_q.timer2_control | T2_FIXED_ONES};
         end else if (addr_in == INT_REQUEST_OFS) begin
            s_d.rdata = {13'h0000, s_q.int_request};
         end else if (addr_in == INT_ENABLE_OFS) begin
            s_d.rdata = {13'h0000, s_q.int_enable};
         end else if (addr_in == INT_PRIORITY_OFS) begin
            s_d.rdata = {14'h0000, s_q.int_priority};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Registers.

   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         s_q <= '0;
         // Counters and reload values are cleared only for a tidy start; software must load them.
         s_q.wide_count <= COUNT_RST;
         s_q.wide_control <= WIDE_CONTROL_RST;
         s_q.timer1_control <= T1_CONTROL_RST;
         s_q.timer2_control <= T2_CONTROL_RST;
         s_q.vector_out <= WIDE_OVF_VECTOR;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs.

   assign rdata_out = s_q.rdata;
   assign wide_timer_output_out = s_q.wide_control[OUTPUT_BIT];
   assign timer1_output_out = s_q.timer1_control[OUTPUT_BIT];
   assign timer2_output_out = s_q.timer2_control[OUTPUT_BIT];
   assign wide_irq_out = s_q.wide_irq;
   assign wide_irq_priority_out = s_q.priority_out;
   assign wide_irq_vector_out = s_q.vector_out;
   assign timer1_irq_out = s_q.timer1_irq;
   assign timer2_irq_out = s_q.timer2_irq;

endmodule
`default_nettype wire

// ### tb_auto_reload_timers.sv
// Self-checking testbench for the auto-reload timer block.
`timescale 1ns/1ps
`default_nettype none
module tb_auto_reload_timers;
   import timers_pkg::*;
   logic core_clk_in = 1'b0;
   logic nrst_in = 1'b0;
   logic [7:0] addr_in = 8'h00;
   logic [15:0] wdata_in = 16'h0000;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic [2:0] ev = 3'h0;
   logic [15:0] rdata_out, wide_irq_vector_out;
   logic [1:0] wide_irq_priority_out;
   logic wide_timer_output_out, timer1_output_out, timer2_output_out;
   logic wide_irq_out, timer1_irq_out, timer2_irq_out;
   logic [23:0] exp_q[$];
   logic [23:0] note;
   logic rd_q = 1'b0;
   int fail_count = 0;
   int num_checks = 0;
   int cycles = 0;
   int seed = 32'h1026ED67;
   int n;
   int sh[6] = '{0, 1, 2, 3, 5, 8};
   logic [7:0] cnt_ofs[3] = '{WIDE_COUNT_OFS, T1_COUNT_OFS, T2_COUNT_OFS};
   logic [7:0] ctl_ofs[3] = '{WIDE_CONTROL_OFS, T1_CONTROL_OFS, T2_CONTROL_OFS};

   auto_reload_timers dut (
      .core_clk_in(core_clk_in), .nrst_in(nrst_in), .addr_in(addr_in), .wdata_in(wdata_in),
      .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .wide_timer_event_in(ev[0]),
      .timer1_event_in(ev[1]), .timer2_event_in(ev[2]), .wide_timer_output_out(wide_timer_output_out),
      .timer1_output_out(timer1_output_out), .timer2_output_out(timer2_output_out),
      .wide_irq_out(wide_irq_out), .wide_irq_priority_out(wide_irq_priority_out),
      .wide_irq_vector_out(wide_irq_vector_out), .timer1_irq_out(timer1_irq_out),
      .timer2_irq_out(timer2_irq_out));

   always #50 core_clk_in = ~core_clk_in;
   ////////////////////////////////////////////////////////////////////////////
   task automatic summarize();
      if (fail_count == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Every bus task drives both strobes once, so back-to-back calls never double-assign.
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      rd_in <= 1'b0;
      @(posedge core_clk_in);
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      addr_in <= a;
      wr_in <= 1'b0;
      rd_in <= 1'b1;
      exp_q.push_back({a, e});
      @(posedge core_clk_in);
   endtask
   task automatic idle(input int k);
      wr_in <= 1'b0;
      rd_in <= 1'b0;
      repeat (k) @(posedge core_clk_in);
   endtask
   // Pulse widths stay at two clocks or more so the synchroniser always sees them.
   task automatic pulse(input int i);
      ev[i] <= 1'b1;
      idle(2 + ($unsigned($random(seed)) % 3));
      ev[i] <= 1'b0;
      idle(2 + ($unsigned($random(seed)) % 3));
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Read data stand only in the cycle after the strobe, so they are taken there.
   always @(posedge core_clk_in) begin
      cycles++;
      if (rd_q) begin
         note = exp_q.pop_front();
         check($sformatf("read of address %h", note[23:16]), rdata_out, note[15:0]);
      end
      rd_q = rd_in;
      if (cycles == 6000) begin
         fail_count++;
         summarize();
      end
   end

   initial begin
      repeat (16) @(posedge core_clk_in);
      nrst_in <= 1'b1;
      @(posedge core_clk_in);
      rd(T1_CONTROL_OFS, 16'h0070);
      rd(WIDE_CONTROL_OFS, 16'h0070);
      rd(T2_CONTROL_OFS, 16'h0040);
      wr(T1_CONTROL_OFS, 16'h0080);
      rd(T1_CONTROL_OFS, 16'h00F0);
      rd(8'h90, 16'h0000);
      idle(1);
      check("timer1 output", {15'h0, timer1_output_out}, 16'h0001);
      // Reload FFFD makes the wide timer overflow every third pulse.
      wr(WIDE_COUNT_OFS, 16'hFFFE);
      rd(WIDE_RELOAD_OFS, 16'hFFFE);
      wr(WIDE_RELOAD_OFS, 16'hFFFD);
      wr(WIDE_CONTROL_OFS, 16'h0008);
      idle(4);
      rd(WIDE_CONTROL_OFS, 16'h00F8);
      wr(WIDE_CONTROL_OFS, 16'h0080);
      rd(WIDE_COUNT_OFS, 16'hFFFE);
      idle(20);
      rd(WIDE_COUNT_OFS, 16'hFFFE);
      rd(INT_REQUEST_OFS, 16'h0001);
      idle(2);
      check("wide irq", {15'h0, wide_irq_out}, 16'h0000);
      wr(INT_ENABLE_OFS, 16'h0003);
      idle(2);
      check("wide irq", {15'h0, wide_irq_out}, 16'h0001);
      wr(INT_REQUEST_OFS, 16'h0000);
      idle(2);
      check("wide irq", {15'h0, wide_irq_out}, 16'h0000);
      for (n = 0; n < 4; n++) begin
         wr(INT_PRIORITY_OFS, n[15:0]);
         idle(2);
         check("priority", {14'h0, wide_irq_priority_out}, n[15:0]);
      end
      check("vector", wide_irq_vector_out, 16'h001A);
      for (n = 0; n < 6; n++) begin
         wr(T1_COUNT_OFS, 16'h0000);
         wr(T1_CONTROL_OFS, 16'h0008 | n[15:0]);
         idle(255);
         wr(T1_CONTROL_OFS, n[15:0]);
         rd(T1_COUNT_OFS, 16'((256 >> sh[n]) & 255));
      end
      wr(T1_CONTROL_OFS, 16'h0008);
      wr(T1_COUNT_OFS, 16'h0040);
      idle(2);
      wr(T1_CONTROL_OFS, 16'h0000);
      rd(T1_COUNT_OFS, 16'h0043);
      rd(T1_RELOAD_OFS, 16'h0040);
      wr(INT_ENABLE_OFS, 16'h0000);
      for (n = 0; n < 6; n++) begin
         wr(cnt_ofs[n / 2], 16'h0000);
         wr(ctl_ofs[n / 2], 16'h000E | 16'(n % 2));
         repeat (3) pulse(n / 2);
         idle(6);
         wr(ctl_ofs[n / 2], 16'h0000);
         rd(cnt_ofs[n / 2], 16'h0003);
      end
      wr(INT_REQUEST_OFS, 16'h0000);
      wr(T2_CONTROL_OFS, 16'h0010);
      wr(T1_COUNT_OFS, 16'h00FE);
      wr(T2_COUNT_OFS, 16'h00FF);
      wr(T1_CONTROL_OFS, 16'h0008);
      idle(2);
      wr(T1_CONTROL_OFS, 16'h0000);
      rd(T1_COUNT_OFS, 16'h00FF);
      rd(T2_COUNT_OFS, 16'h00FF);
      rd(INT_REQUEST_OFS, 16'h0004);
      rd(T2_CONTROL_OFS, 16'h00D0);
      idle(1);
      check("timer2 output", {15'h0, timer2_output_out}, 16'h0001);
      // Only the joined overflow flag is set, so only the timer 2 request may rise.
      wr(INT_ENABLE_OFS, 16'h0006);
      idle(2);
      check("timer2 irq", {15'h0, timer2_irq_out}, 16'h0001);
      check("timer1 irq", {15'h0, timer1_irq_out}, 16'h0000);
      idle(4);
      summarize();
   end
endmodule
`default_nettype wire

// ### timers_checker.sv
// Port-level assertions for the auto-reload timer block.
`timescale 1ns/1ps
`default_nettype none
module timers_checker
   import timers_pkg::*;
(
   // Clock, reset and register port
   input wire logic core_clk_in,
   input wire logic nrst_in,
   input wire logic [7:0] addr_in,
   input wire logic [15:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [15:0] rdata_out,
   // Outputs under watch
   input wire logic wide_timer_output_out,
   input wire logic timer1_output_out,
   input wire logic wide_irq_out,
   input wire logic [1:0] wide_irq_priority_out,
   input wire logic [15:0] wide_irq_vector_out,
   input wire logic timer1_irq_out
);
   default clocking main_edge @(posedge core_clk_in); endclocking
   default disable iff (!nrst_in);
   ////////////////////////////////////////////////////////////////////////////
   a_vector_fixed: assert property (wide_irq_vector_out == WIDE_OVF_VECTOR)
      else $error("vector output is not the fixed value");
   a_t1_ones: assert property (rd_in && addr_in == T1_CONTROL_OFS |=> rdata_out[6:4] == 3'b111)
      else $error("timer 1 control fixed bits not read as ones");
   a_wide_ones: assert property (rd_in && addr_in == WIDE_CONTROL_OFS |=> rdata_out[6:4] == 3'b111)
      else $error("wide control fixed bits not read as ones");
   a_t1_out_pin: assert property (rd_in && addr_in == T1_CONTROL_OFS |=> rdata_out[7] == $past(timer1_output_out))
      else $error("timer 1 output pin differs from its control bit");
   a_priority_copy: assert property (wr_in && addr_in == INT_PRIORITY_OFS ##1 !wr_in
      |=> wide_irq_priority_out == $past(wdata_in[1:0], 2))
      else $error("priority output does not follow the written flags");
   a_wide_masked: assert property (wr_in && addr_in == INT_ENABLE_OFS && !wdata_in[0]
      ##1 !(wr_in && addr_in == INT_ENABLE_OFS) |=> !wide_irq_out)
      else $error("wide request forwarded while disabled");
   a_t1_masked: assert property (wr_in && addr_in == INT_ENABLE_OFS && !wdata_in[1]
      ##1 !(wr_in && addr_in == INT_ENABLE_OFS) |=> !timer1_irq_out)
      else $error("timer 1 request forwarded while disabled");
   // A toggle of the output in the clearing cycle means an overflow won over the clear.
   a_flag_clear: assert property (wr_in && addr_in == INT_REQUEST_OFS && !wdata_in[0]
      ##1 ($stable(wide_timer_output_out) && !(wr_in && addr_in == INT_REQUEST_OFS)) |=> !wide_irq_out)
      else $error("wide request still raised after clearing");
   a_reset_outs: assert property ($rose(nrst_in) |-> !wide_timer_output_out && !timer1_output_out
      && wide_irq_priority_out == 2'b00 && rdata_out == 16'h0000)
      else $error("outputs not at reset levels after reset");
endmodule
bind auto_reload_timers timers_checker chk (
   .core_clk_in(core_clk_in), .nrst_in(nrst_in), .addr_in(addr_in), .wdata_in(wdata_in),
   .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .wide_timer_output_out(wide_timer_output_out),
   .timer1_output_out(timer1_output_out), .wide_irq_out(wide_irq_out),
   .wide_irq_priority_out(wide_irq_priority_out), .wide_irq_vector_out(wide_irq_vector_out),
   .timer1_irq_out(timer1_irq_out));
`default_nettype wire

// ### timers_pkg.sv
// Constants shared by the auto-reload timer block.
`default_nettype none
package timers_pkg;
   // Register offsets on the plain register port.
   localparam logic [7:0] WIDE_COUNT_OFS = 8'h62;
   localparam logic [7:0] WIDE_RELOAD_OFS = 8'h64;
   localparam logic [7:0] WIDE_CONTROL_OFS = 8'h66;
   localparam logic [7:0] T1_COUNT_OFS = 8'h68;
   localparam logic [7:0] T2_COUNT_OFS = 8'h69;
   localparam logic [7:0] T1_RELOAD_OFS = 8'h6A;
   localparam logic [7:0] T2_RELOAD_OFS = 8'h6B;
   localparam logic [7:0] T1_CONTROL_OFS = 8'h6C;
   localparam logic [7:0] T2_CONTROL_OFS = 8'h6D;
   localparam logic [7:0] INT_REQUEST_OFS = 8'h80;
   localparam logic [7:0] INT_ENABLE_OFS = 8'h81;
   localparam logic [7:0] INT_PRIORITY_OFS = 8'h82;
   // Control register field positions.
   localparam int CLKSEL_LSB = 0;
   localparam int RUN_BIT = 3;
   localparam int PAIR_WIDE_BIT = 4;
   localparam int PAIR_PWM_BIT = 5;
   localparam int OUTPUT_BIT = 7;
   // Bits that ignore writes and read as one.
   localparam logic [7:0] WIDE_FIXED_ONES = 8'h70;
   localparam logic [7:0] T1_FIXED_ONES = 8'h70;
   localparam logic [7:0] T2_FIXED_ONES = 8'h40;
   // Reset values.
   localparam logic [7:0] WIDE_CONTROL_RST = 8'h70;
   localparam logic [7:0] T1_CONTROL_RST = 8'h70;
   localparam logic [7:0] T2_CONTROL_RST = 8'h40;
   localparam logic [15:0] COUNT_RST = 16'h0000;
   // Interrupt flag positions in the request and enable registers.
   localparam int WIDE_IRQ_BIT = 0;
   localparam int T1_IRQ_BIT = 1;
   localparam int T2_IRQ_BIT = 2;
   localparam logic [15:0] WIDE_OVF_VECTOR = 16'h001A;
   // Count clock selections.
   localparam logic [2:0] SEL_DIV1 = 3'h0;
   localparam logic [2:0] SEL_DIV2 = 3'h1;
   localparam logic [2:0] SEL_DIV4 = 3'h2;
   localparam logic [2:0] SEL_DIV8 = 3'h3;
   localparam logic [2:0] SEL_DIV32 = 3'h4;
   localparam logic [2:0] SEL_DIV256 = 3'h5;
   localparam logic [2:0] SEL_EVT_RISE = 3'h6;
   localparam logic [2:0] SEL_EVT_FALL = 3'h7;
endpackage
`default_nettype wire
